// ### selc_exc_ctl.sv
// Exception sequencing, break flag protection, low-power control and status registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE1: Entry requests stacking and sets mask; return requests register restore.
// RULE2: Arbitration result latched at entry; held until stacking completes.
// RULE3: Hardware requests checked only at instruction end, unmasked and enabled.
// RULE4: Lowest numbered pending source wins when several are pending.
// RULE5: After return, pending requests are rechecked before the next instruction.
// RULE6: Index high register is never part of the stacking request.
// RULE7: Software interrupt starts entry regardless of the mask.
// RULE8: Software entry pushes PC, hardware entry pushes PC minus one.
// RULE9: Any reset source overrides everything and skips arbitration.
// RULE10: Break request forces entry through the software interrupt vector.
// RULE11: In break, other modules' flags clear only when break_clear_enable is set.
// RULE12: Flags cleared in break remain cleared after break ends.
// RULE13: Two-step clears stay blocked in break; second step works after break.
// RULE14: Wait or stop entry clears mask and stops CPU clocks.
// RULE15: Wait keeps peripheral clocks; enabled interrupt stacks one cycle later.
// RULE16: Reset or break ends wait and stop; break sets break_exit_flag.
// RULE17: Watchdog keeps running in wait when watchdog_disable is low.
// RULE18: Stop gates clock outputs, holds counter cleared, stacks after recovery.
// RULE19: Recovery is 4096 xclk cycles, or 32 with short_stop_recovery.
// RULE20: break_exit_flag clears on a written zero and on any reset.
// RULE21: Six reset cause flags clear on read; power-on sets only its own.
// RULE22: Flags: power-on, pin, watchdog, bad opcode, bad opcode address, low supply.
// RULE23: break_clear_enable is read/write; one allows clearing, zero blocks it.
// RULE24: Cause flags in bits 0..5, exit flag bit 1, unused bits read zero.
module selc_exc_ctl
	import selc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// CPU core handshake
	input wire logic instr_done,
	input wire logic i_mask,
	input wire logic soft_irq_exec,
	input wire logic irq_return_exec,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic stack_done,
	// Interrupting peripherals and break module
	input wire logic [NIRQ-1:0] irq_req,
	input wire logic [NIRQ-1:0] irq_en,
	input wire logic brk_req,
	// Configuration
	input wire logic watchdog_disable,
	input wire logic short_stop_recovery,
	// Reset sources
	input wire logic por_pulse,
	input wire logic ext_rst_n,
	input wire logic wdog_expire,
	input wire logic bad_opcode,
	input wire logic opcode_fetch,
	input wire logic unmapped_addr,
	input wire logic low_supply,
	// Crystal clock, sampled as a level
	input wire logic xclk,
	// Register port
	input wire logic [1:0] reg_sel,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Exception requests to the CPU
	output logic stack_req,
	output logic [3:0] vector_sel,
	output logic push_pc_minus1,
	output logic restore_req,
	output logic set_mask,
	output logic clr_mask,
	// Clock and mode controls
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic clkgen_out_en,
	output logic clkgen_xclk_en,
	output logic wdog_run_en,
	output logic in_break,
	output logic flag_clear_allow,
	output logic sys_reset
);

	typedef struct packed {
		selc_state_e st;
		logic [1:0] pin_sy;
		logic [2:0] xc_sy;
		logic [RCNT_W-1:0] rcnt;
		logic wake_brk;
		logic post_rti;
		logic brk_exit;
		logic clr_en;
		logic [7:0] cause;
		logic [7:0] rdata;
		logic stack_req;
		logic [3:0] vec;
		logic pcm1;
		logic restore_req;
		logic set_mask;
		logic clr_mask;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic out_en;
		logic xclk_en;
		logic wdog_en;
		logic in_break;
		logic clr_allow;
		logic sys_reset;
	} selc_regs_s;

	localparam selc_regs_s REGS_RST = '{
		st: ST_RESET, pin_sy: 2'h3, xc_sy: 3'h0, rcnt: RCNT_ZERO, wake_brk: 1'b0,
		post_rti: 1'b0, brk_exit: 1'b0, clr_en: 1'b0, cause: CAUSE_POR_ONLY,
		rdata: REG_ZERO, stack_req: 1'b0, vec: VEC_NONE, pcm1: 1'b0,
		restore_req: 1'b0, set_mask: 1'b0, clr_mask: 1'b0, cpu_clk_en: 1'b0,
		periph_clk_en: 1'b0, out_en: 1'b1, xclk_en: 1'b1, wdog_en: 1'b0,
		in_break: 1'b0, clr_allow: 1'b1, sys_reset: 1'b1
	};

	selc_regs_s s;
	selc_regs_s n;
	logic [NIRQ-1:0] hw_pend;
	logic hw_ok;
	logic rst_any;
	logic pin_rst;
	logic xtick;
	logic boundary;
	logic [RCNT_W-1:0] rlimit;
	logic [7:0] cause_hit;

	function automatic logic [3:0] pick(input logic [NIRQ-1:0] p);
		logic [3:0] r;
		r = VEC_NONE;
		for (int i = NIRQ - 1; i >= 0; i--) begin
			if (p[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : pick

	always_comb begin
		n = s;
		n.stack_req = 1'b0;
		n.restore_req = 1'b0;
		n.set_mask = 1'b0;
		n.clr_mask = 1'b0;
		n.post_rti = 1'b0;
		n.pin_sy = {s.pin_sy[0], ext_rst_n};
		n.xc_sy = {s.xc_sy[1:0], xclk};
		pin_rst = ~s.pin_sy[1];
		xtick = s.xc_sy[1] & ~s.xc_sy[2];
		hw_pend = irq_req & irq_en;
		// RULE3 unmasked enabled check
		hw_ok = ~i_mask & (|hw_pend);
		boundary = instr_done | s.post_rti;
		// RULE19 recovery length select
		rlimit = short_stop_recovery ? RECOV_SHORT_XCLK : RECOV_LONG_XCLK;
		// RULE22 cause sources, RULE17 watchdog only when enabled
		cause_hit = REG_ZERO;
		cause_hit[BIT_POR] = por_pulse;
		cause_hit[BIT_PIN] = pin_rst;
		cause_hit[BIT_WDOG] = wdog_expire & ~watchdog_disable;
		cause_hit[BIT_BADOP] = bad_opcode;
		cause_hit[BIT_BADADR] = opcode_fetch & unmapped_addr;
		cause_hit[BIT_LOWSUP] = low_supply;
		rst_any = |cause_hit;

		// Register port; hardware sets below win over these clears
		if (reg_rd) begin
			unique case (reg_sel)
				REG_BRK_STATUS: n.rdata = 8'(s.brk_exit) << BIT_BRK_EXIT;
				REG_RST_CAUSE: n.rdata = s.cause;
				REG_BRK_CTRL: n.rdata = 8'(s.clr_en) << BIT_CLR_EN;
				default: n.rdata = REG_ZERO;
			endcase
			// RULE21 read clears cause flags
			if (reg_sel == REG_RST_CAUSE) begin
				n.cause = REG_ZERO;
			end
		end
		if (reg_wr) begin
			// RULE20 written zero clears exit flag
			if (reg_sel == REG_BRK_STATUS && !reg_wdata[BIT_BRK_EXIT]) begin
				n.brk_exit = 1'b0;
			end
			// RULE23 clear enable write
			if (reg_sel == REG_BRK_CTRL) begin
				n.clr_en = reg_wdata[BIT_CLR_EN];
			end
		end

		unique case (s.st)
			ST_RUN: begin
				if (boundary) begin
					// RULE10 break forced through soft vector
					if (brk_req) begin
						n.vec = VEC_SOFT;
						n.pcm1 = 1'b0;
						n.in_break = 1'b1;
						n.st = ST_STACK;
					// RULE7 software entry ignores mask
					end else if (soft_irq_exec) begin
						n.vec = VEC_SOFT;
						n.pcm1 = 1'b0;
						n.st = ST_STACK;
					// RULE1 restore on return, RULE5 recheck next cycle
					end else if (irq_return_exec) begin
						n.restore_req = 1'b1;
						n.post_rti = 1'b1;
						n.in_break = 1'b0;
					// RULE14 low-power entry clears mask
					end else if (wait_exec) begin
						n.clr_mask = 1'b1;
						n.st = ST_WAIT;
					end else if (stop_exec) begin
						n.clr_mask = 1'b1;
						n.rcnt = RCNT_ZERO;
						n.st = ST_STOP;
					// RULE4 highest priority, RULE8 PC minus one
					end else if (hw_ok) begin
						n.vec = pick(hw_pend);
						n.pcm1 = 1'b1;
						n.st = ST_STACK;
					end
				end
			end
			ST_STACK: begin
				// RULE2 latched choice held until serviced
				if (stack_done) begin
					n.st = ST_RUN;
				end
			end
			ST_WAIT: begin
				// RULE16 break exit sets flag, RULE15 wake
				if (brk_req) begin
					n.brk_exit = 1'b1;
					n.vec = VEC_SOFT;
					n.pcm1 = 1'b0;
					n.in_break = 1'b1;
					n.st = ST_STACK;
				end else if (hw_ok) begin
					n.vec = pick(hw_pend);
					n.pcm1 = 1'b1;
					n.st = ST_STACK;
				end
			end
			ST_STOP: begin
				// RULE18 counter held cleared until wake
				n.rcnt = RCNT_ZERO;
				if (brk_req) begin
					n.brk_exit = 1'b1;
					n.wake_brk = 1'b1;
					n.st = ST_RECOV;
				end else if (hw_ok) begin
					n.wake_brk = 1'b0;
					n.st = ST_RECOV;
				end
			end
			ST_RECOV: begin
				// RULE18 stacking only after recovery, RULE19
				if (s.rcnt == rlimit) begin
					if (s.wake_brk) begin
						n.vec = VEC_SOFT;
						n.pcm1 = 1'b0;
						n.in_break = 1'b1;
						n.st = ST_STACK;
					end else if (|hw_pend) begin
						n.vec = pick(hw_pend);
						n.pcm1 = 1'b1;
						n.st = ST_STACK;
					end else begin
						n.st = ST_RUN;
					end
				end else if (xtick) begin
					n.rcnt = s.rcnt + RCNT_ONE;
				end
			end
			ST_RESET: begin
				if (!rst_any) begin
					n.st = ST_RUN;
				end
			end
		endcase

		// RULE1 entry sets mask; RULE6 index high never requested
		if (s.st != ST_STACK && n.st == ST_STACK) begin
			n.stack_req = 1'b1;
			n.set_mask = 1'b1;
		end

		// RULE9 reset overrides all exception activity
		if (rst_any) begin
			n.st = ST_RESET;
			n.stack_req = 1'b0;
			n.set_mask = 1'b0;
			n.restore_req = 1'b0;
			n.clr_mask = 1'b0;
			n.vec = VEC_NONE;
			n.in_break = 1'b0;
			n.wake_brk = 1'b0;
			n.clr_en = 1'b0;
			// RULE20 any reset clears exit flag
			n.brk_exit = 1'b0;
			// RULE21 power-on clears others, RULE24 bit layout
			n.cause = por_pulse ? CAUSE_POR_ONLY : (n.cause | cause_hit);
		end

		// RULE14 CPU unclocked in wait and stop, RULE15 peripherals run in wait
		n.cpu_clk_en = (n.st == ST_RUN) || (n.st == ST_STACK);
		n.periph_clk_en = (n.st != ST_STOP) && (n.st != ST_RECOV) && (n.st != ST_RESET);
		// RULE18 clock generator outputs gated in stop
		n.out_en = (n.st != ST_STOP) && (n.st != ST_RECOV);
		n.xclk_en = n.st != ST_STOP;
		// RULE17 watchdog active in wait
		n.wdog_en = ~watchdog_disable && n.st != ST_STOP && n.st != ST_RECOV;
		// RULE11 RULE12 RULE13 clearing gate for other modules
		n.clr_allow = ~n.in_break | n.clr_en;
		n.sys_reset = n.st == ST_RESET;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s <= REGS_RST;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign stack_req = s.stack_req;
	assign vector_sel = s.vec;
	assign push_pc_minus1 = s.pcm1;
	assign restore_req = s.restore_req;
	assign set_mask = s.set_mask;
	assign clr_mask = s.clr_mask;
	assign cpu_clk_en = s.cpu_clk_en;
	assign periph_clk_en = s.periph_clk_en;
	assign clkgen_out_en = s.out_en;
	assign clkgen_xclk_en = s.xclk_en;
	assign wdog_run_en = s.wdog_en;
	assign in_break = s.in_break;
	assign flag_clear_allow = s.clr_allow;
	assign sys_reset = s.sys_reset;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_reset_wins: assert property (rst_any |=> sys_reset && !stack_req) // RULE9
		else $error("reset source did not override");
	a_entry_mask: assert property (stack_req |-> set_mask ##1 !stack_req) // RULE1
		else $error("entry without mask set");
	a_latch_hold: assert property ((s.st == ST_STACK && !stack_done && !rst_any)
		|=> $stable(vector_sel)) // RULE2
		else $error("latched vector changed");
	a_masked_skip: assert property ((s.st == ST_RUN && instr_done && i_mask && !brk_req
		&& !soft_irq_exec && !s.post_rti) |=> !stack_req) // RULE3
		else $error("masked request was taken");
	a_prio_zero: assert property ((s.st == ST_RUN && instr_done && !i_mask && hw_pend[0]
		&& !brk_req && !soft_irq_exec && !irq_return_exec
		&& !wait_exec && !stop_exec && !rst_any)
		|=> stack_req && vector_sel == 4'h0 && push_pc_minus1) // RULE4
		else $error("highest priority not chosen");
	a_soft_entry: assert property ((s.st == ST_RUN && instr_done && soft_irq_exec && !brk_req
		&& !rst_any) |=> stack_req && vector_sel == VEC_SOFT && !push_pc_minus1) // RULE7
		else $error("soft interrupt entry wrong");
	a_wait_wake: assert property ((s.st == ST_WAIT && hw_ok && !brk_req && !rst_any)
		|=> stack_req) // RULE15
		else $error("wait wake not one cycle");
	a_recov_len: assert property ((s.st == ST_RECOV && n.st == ST_STACK && !rst_any)
		|-> s.rcnt == rlimit) // RULE19
		else $error("recovery length wrong");
	a_brk_exit: assert property ((s.st == ST_STOP && brk_req && !rst_any)
		|=> s.brk_exit && clkgen_xclk_en && !cpu_clk_en) // RULE16
		else $error("break exit flag not set");
	a_cause_clear: assert property ((reg_rd && reg_sel == REG_RST_CAUSE && !rst_any)
		|=> s.cause == REG_ZERO) // RULE21
		else $error("cause not cleared by read");
	a_flag_guard: assert property ((in_break && !s.clr_en) |-> !flag_clear_allow) // RULE11
		else $error("flags clearable in break");
	a_lowpwr_mask: assert property ((s.st == ST_RUN && instr_done && wait_exec && !brk_req
		&& !soft_irq_exec && !irq_return_exec && !rst_any)
		|=> clr_mask && !cpu_clk_en) // RULE14
		else $error("wait entry did not clear mask");

endmodule : selc_exc_ctl

`default_nettype wire

// ### selc_pkg.sv
// Shared constants and types for the exception and low-power sequencer
package selc_pkg;

	localparam int NIRQ = 8;

	// Register select codes on the register port
	localparam logic [1:0] REG_BRK_STATUS = 2'h0;
	localparam logic [1:0] REG_RST_CAUSE = 2'h1;
	localparam logic [1:0] REG_BRK_CTRL = 2'h2;

	// Field positions inside the 8-bit registers
	localparam int BIT_BRK_EXIT = 1;
	localparam int BIT_CLR_EN = 7;
	localparam int BIT_POR = 0;
	localparam int BIT_PIN = 1;
	localparam int BIT_WDOG = 2;
	localparam int BIT_BADOP = 3;
	localparam int BIT_BADADR = 4;
	localparam int BIT_LOWSUP = 5;

	// Reset values
	localparam logic [7:0] CAUSE_POR_ONLY = 8'h01;
	localparam logic [7:0] REG_ZERO = 8'h00;

	// Stop recovery lengths in clockgen_xclk cycles
	localparam int RCNT_W = 13;
	localparam logic [RCNT_W-1:0] RECOV_LONG_XCLK = 13'h1000;
	localparam logic [RCNT_W-1:0] RECOV_SHORT_XCLK = 13'h0020;
	localparam logic [RCNT_W-1:0] RCNT_ZERO = 13'h0000;
	localparam logic [RCNT_W-1:0] RCNT_ONE = 13'h0001;

	// Vector select codes: 0..7 hardware sources, 0 highest priority
	localparam logic [3:0] VEC_SOFT = 4'h8;
	localparam logic [3:0] VEC_NONE = 4'hF;

	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_STACK = 6'h02,
		ST_WAIT = 6'h04,
		ST_STOP = 6'h08,
		ST_RECOV = 6'h10,
		ST_RESET = 6'h20
	} selc_state_e;

endpackage : selc_pkg

// ### selc_cpu_model.sv
// Behavioural CPU core answering the sequencer's stacking, mask and return requests
`timescale 1ns/1ps
`default_nettype none
module selc_cpu_model #(
	parameter int LAT = 3
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic sys_reset,
	// Requests from the sequencer
	input wire logic stack_req,
	input wire logic set_mask,
	input wire logic clr_mask,
	input wire logic restore_req,
	// Answers to the sequencer
	output logic stack_done,
	output logic i_mask
);
	logic [3:0] cnt;
	logic mask_q;

	// mask drops with the return or low-power request
	assign i_mask = mask_q & ~restore_req & ~clr_mask;

	// stacking takes a fixed time, mask set on entry
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 4'h0;
			stack_done <= 1'b0;
			mask_q <= 1'b1;
		end else begin
			stack_done <= (cnt == 4'h1);
			if (stack_req)
				cnt <= 4'(LAT);
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
			if (sys_reset || set_mask)
				mask_q <= 1'b1;
			else if (clr_mask || restore_req)
				mask_q <= 1'b0;
		end
	end
endmodule : selc_cpu_model
`default_nettype wire

// ### sys_exception_lowpower_ctl_tb_top.sv
// Self-checking testbench for the exception and low-power sequencer
`timescale 1ns/1ps
`default_nettype none
module sys_exception_lowpower_ctl_tb_top;
	import selc_pkg::*;
	logic ref_clk, nrst, instr_done, soft_irq_exec, irq_return_exec;
	logic wait_exec, stop_exec, brk_req, xclk;
	logic watchdog_disable, short_stop_recovery, por_pulse, ext_rst_n, wdog_expire;
	logic bad_opcode, opcode_fetch, unmapped_addr, low_supply, reg_rd, reg_wr;
	logic [NIRQ-1:0] irq_req, irq_en;
	logic [1:0] reg_sel;
	logic [7:0] reg_wdata, reg_rdata;
	logic i_mask, stack_done, stack_req, push_pc_minus1, restore_req, set_mask, clr_mask;
	logic [3:0] vector_sel;
	logic cpu_clk_en, periph_clk_en, clkgen_out_en, clkgen_xclk_en, wdog_run_en, in_break;
	logic flag_clear_allow, sys_reset;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc;

	selc_exc_ctl DUT (
		.ref_clk, .nrst, .instr_done, .i_mask, .soft_irq_exec, .irq_return_exec,
		.wait_exec, .stop_exec,
		.stack_done, .irq_req, .irq_en, .brk_req, .watchdog_disable, .short_stop_recovery,
		.por_pulse, .ext_rst_n, .wdog_expire, .bad_opcode, .opcode_fetch, .unmapped_addr,
		.low_supply, .xclk, .reg_sel, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .stack_req,
		.vector_sel, .push_pc_minus1, .restore_req, .set_mask, .clr_mask, .cpu_clk_en,
		.periph_clk_en, .clkgen_out_en, .clkgen_xclk_en, .wdog_run_en, .in_break,
		.flag_clear_allow, .sys_reset
	);

	selc_cpu_model cpu (
		.ref_clk, .nrst, .sys_reset, .stack_req, .set_mask, .clr_mask, .restore_req,
		.stack_done, .i_mask
	);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Crystal clock at a fifth of the bus rate
	initial begin
		xclk = 1'b0;
		forever #50 xclk = ~xclk;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	// Instruction boundary, kind bits are stop, wait, return, soft
	task instr(input logic [3:0] k);
		@(posedge ref_clk);
		instr_done <= 1'b1;
		{stop_exec, wait_exec, irq_return_exec, soft_irq_exec} <= k;
		@(posedge ref_clk);
		instr_done <= 1'b0;
		{stop_exec, wait_exec, irq_return_exec, soft_irq_exec} <= 4'h0;
	endtask : instr

	task wait_entry(input int lim);
		cyc = 0;
		#1;
		while (stack_req !== 1'b1 && cyc < lim) begin
			@(posedge ref_clk);
			#1;
			cyc++;
		end
		check({7'h0, stack_req}, 8'h01);
	endtask : wait_entry

	task no_entry;
		repeat (6) begin
			#1;
			check({7'h0, stack_req}, 8'h00);
			@(posedge ref_clk);
		end
	endtask : no_entry

	task rd(input logic [1:0] s, input logic [7:0] e);
		@(posedge ref_clk);
		reg_sel <= s;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd

	task wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge ref_clk);
		reg_sel <= s;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task set_src(input int k, input logic v);
		@(posedge ref_clk);
		case (k)
			0: por_pulse <= v;
			1: ext_rst_n <= ~v;
			2: wdog_expire <= v;
			3: bad_opcode <= v;
			4: {opcode_fetch, unmapped_addr} <= {v, v};
			default: low_supply <= v;
		endcase
	endtask : set_src

	task wrap_up;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	initial begin
		#1_500_000;
		n_mismatch++;
		wrap_up;
	end

	initial begin
		nrst = 1'b0;
		{instr_done, soft_irq_exec, irq_return_exec, wait_exec, stop_exec, brk_req} = 6'h00;
		{watchdog_disable, short_stop_recovery, por_pulse, wdog_expire, bad_opcode} = 5'h00;
		{opcode_fetch, unmapped_addr, low_supply, reg_rd, reg_wr} = 5'h00;
		ext_rst_n = 1'b1;
		irq_req = 8'h00;
		irq_en = 8'hFF;
		reg_sel = 2'h0;
		reg_wdata = 8'h00;
		tick(12);
		nrst <= 1'b1;
		tick(2);
		rd(REG_RST_CAUSE, CAUSE_POR_ONLY);
		rd(REG_RST_CAUSE, REG_ZERO);
		rd(2'h3, REG_ZERO);
		rd(REG_BRK_CTRL, REG_ZERO);
		wr(REG_BRK_CTRL, 8'h80);
		rd(REG_BRK_CTRL, 8'h80);
		wr(REG_BRK_CTRL, REG_ZERO);
		instr(4'h2);
		@(posedge ref_clk);
		irq_req <= 8'h0C;
		instr(4'h0);
		wait_entry(4);
		check({4'h0, vector_sel}, 8'h02);
		check({7'h0, push_pc_minus1}, 8'h01);
		tick(8);
		instr(4'h0);
		no_entry;
		instr(4'h1);
		wait_entry(4);
		check({4'h0, vector_sel}, 8'h08);
		check({7'h0, push_pc_minus1}, 8'h00);
		tick(8);
		irq_req <= 8'h08;
		instr(4'h2);
		wait_entry(6);
		check({4'h0, vector_sel}, 8'h03);
		tick(8);
		irq_req <= 8'h01;
		irq_en <= 8'hFE;
		instr(4'h2);
		no_entry;
		irq_req <= 8'h00;
		irq_en <= 8'hFF;
		instr(4'h4);
		tick(2);
		#1;
		check({5'h0, cpu_clk_en, periph_clk_en, wdog_run_en}, 8'h03);
		@(posedge ref_clk);
		brk_req <= 1'b1;
		wait_entry(4);
		check({4'h0, vector_sel}, 8'h08);
		@(posedge ref_clk);
		brk_req <= 1'b0;
		tick(8);
		#1;
		check({6'h0, in_break, flag_clear_allow}, 8'h02);
		wr(REG_BRK_CTRL, 8'h80);
		tick(1);
		#1;
		check({7'h0, flag_clear_allow}, 8'h01);
		wr(REG_BRK_CTRL, REG_ZERO);
		rd(REG_BRK_STATUS, 8'h02);
		wr(REG_BRK_STATUS, REG_ZERO);
		rd(REG_BRK_STATUS, REG_ZERO);
		instr(4'h2);
		tick(3);
		#1;
		check({7'h0, in_break}, 8'h00);
		instr(4'h4);
		@(posedge ref_clk);
		irq_req <= 8'h10;
		wait_entry(3);
		@(posedge ref_clk);
		irq_req <= 8'h00;
		tick(8);
		instr(4'h2);
		for (int m = 1; m >= 0; m--) begin
			@(posedge ref_clk);
			short_stop_recovery <= m[0];
			instr(4'h8);
			tick(2);
			#1;
			check({5'h0, cpu_clk_en, clkgen_out_en, clkgen_xclk_en}, 8'h00);
			check({7'h0, i_mask}, 8'h00);
			@(posedge ref_clk);
			irq_req <= 8'h20;
			wait_entry(25000);
			check({7'h0, cyc >= (m ? 32 : 4096) * 5 - 12 && cyc <= (m ? 32 : 4096) * 5 + 12},
				8'h01);
			@(posedge ref_clk);
			irq_req <= 8'h00;
			tick(8);
			instr(4'h2);
		end
		for (int k = 0; k < 6; k++) begin
			set_src(k, 1'b1);
			tick(3);
			#1;
			check({7'h0, sys_reset}, 8'h01);
			set_src(k, 1'b0);
			tick(10);
			rd(REG_RST_CAUSE, 8'h01 << k);
		end
		@(posedge ref_clk);
		unmapped_addr <= 1'b1;
		tick(3);
		unmapped_addr <= 1'b0;
		tick(10);
		rd(REG_RST_CAUSE, REG_ZERO);
		wrap_up;
	end
endmodule : sys_exception_lowpower_ctl_tb_top
`default_nettype wire
